//--- rtl/picic_regs.vh
// register offsets, field positions, reset values and bus codes of the interrupt controller
// assumes a 12-bit apb byte address and 32-bit data
`ifndef PICIC_REGS_VH
`define PICIC_REGS_VH

// ============================================================
// register byte offsets
`define PICIC_OFF_MASKL0 12'h000
`define PICIC_OFF_MASKU0 12'h004
`define PICIC_OFF_MASKL1 12'h008
`define PICIC_OFF_MASKU1 12'h00C
`define PICIC_OFF_EVSTS 12'h010
`define PICIC_OFF_EVENA 12'h014
`define PICIC_OFF_WIN 12'h018
`define PICIC_PAGE_LP0 4'h1
`define PICIC_PAGE_LP1 4'h2

// ============================================================
// level/priority entry fields
`define PICIC_LP_LVL_HI 5
`define PICIC_LP_LVL_LO 3
`define PICIC_LP_PRI_HI 2
`define PICIC_LP_PRI_LO 0
`define PICIC_RANK_FIXED 4'h4
`define PICIC_PRI_SPLIT 3'h4

// ============================================================
// reset values
`define PICIC_MASK_RST 32'hFFFFFFFF
`define PICIC_LP_RST 6'h00
`define PICIC_EV_RST 2'h0

// ============================================================
// event bits
`define PICIC_EV_SERVED 0
`define PICIC_EV_SPUR 1

// ============================================================
// vector fetch cycle encoding and vectors
`define PICIC_TT_ACK 2'h3
`define PICIC_SIZ_BYTE 2'h1
`define PICIC_VEC_BASE0 8'h40
`define PICIC_VEC_BASE1 8'h80
`define PICIC_VEC_SPUR 8'h18

`endif

//--- rtl/picic_sync.v
// two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to pclk
`timescale 1ns/1ps
`default_nettype none

module picic_sync #(
  parameter W = 7,
  parameter [W-1:0] RST = {W{1'b1}}
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // pins and synchronised levels
  input wire [W-1:0] pin,
  output wire [W-1:0] level
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // ============================================================
  // crossing
  // first stage is read only by the second
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= RST;
      sync_ff <= RST;
    end else begin
      meta_ff <= pin;
      sync_ff <= meta_ff;
    end
  end

  assign level = sync_ff;

endmodule

`default_nettype wire

//--- rtl/picic_arb.v
// one controller instance's arbiter: best active source by combined key
// assumes keys are {level, rank} and index 0 never requests
`timescale 1ns/1ps
`default_nettype none

module picic_arb (
  // active sources and their keys
  input wire [63:0] act,
  input wire [447:0] keys,
  // optional level filter
  input wire lvl_en,
  input wire [2:0] lvl,
  // winner
  output reg [6:0] best_key,
  output reg [5:0] best_idx,
  output reg best_ok
);

  integer i;
  reg [6:0] k;

  // ============================================================
  // linear search; strict compare keeps lowest index on equal keys
  always @* begin
    best_key = 7'h00;
    best_idx = 6'h00;
    best_ok = 1'b0;
    k = 7'h00;
    for (i = 1; i < 64; i = i + 1) begin
      k = keys[i*7 +: 7];
      if (act[i] && (!lvl_en || k[6:4] == lvl) && (!best_ok || k > best_key)) begin
        best_key = k;
        best_idx = i[5:0];
        best_ok = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/picic_top.v
// prioritised interrupt controller: two instances, apb registers, level output to the core
// assumes the core shares pclk, request inputs are on pclk, irq pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "picic_regs.vh"

module picic_top (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // interrupt sources
  input wire [63:8] src0_req,
  input wire [63:1] src1_req,
  input wire [7:1] irq_pin_n,
  // core side
  input wire cyc_valid,
  input wire cyc_read,
  input wire [1:0] cyc_tt,
  input wire [2:0] cyc_tm,
  input wire [1:0] cyc_siz,
  output reg [2:0] ipl,
  output reg ack_done,
  output reg [7:0] ack_vector,
  // event interrupt
  output reg evt_irq
);

  // ============================================================
  // combined key: priorities 0-3 rank 0-3, pin slot 4, 4-7 rank 5-8
  function [6:0] key_of;
    input [5:0] lp;
    reg [3:0] r;
    begin
      r = {1'b0, lp[`PICIC_LP_PRI_HI:`PICIC_LP_PRI_LO]};
      if (lp[`PICIC_LP_PRI_HI:`PICIC_LP_PRI_LO] >= `PICIC_PRI_SPLIT) begin
        r = r + 4'h1;
      end
      key_of = {lp[`PICIC_LP_LVL_HI:`PICIC_LP_LVL_LO], r};
    end
  endfunction

  // ============================================================
  // state
  reg [63:0] mask0_ff;
  reg [63:0] mask1_ff;
  reg [5:0] lp0_ff [0:63];
  reg [5:0] lp1_ff [0:63];
  reg [1:0] ev_sts_ff;
  reg [1:0] ev_ena_ff;
  reg [13:0] win_ff;
  reg [1:0] nxt_ev_set;
  reg [7:0] nxt_vector;
  reg [31:0] nxt_rdata;
  reg nxt_err;

  wire [7:1] pin_lvl_n;
  wire [63:0] act0;
  wire [63:0] act1;
  wire [447:0] keys0;
  wire [447:0] keys1;
  wire [6:0] b0_key;
  wire [6:0] b1_key;
  wire [5:0] b0_idx;
  wire [5:0] b1_idx;
  wire b0_ok;
  wire b1_ok;
  wire [6:0] k0_key;
  wire [6:0] k1_key;
  wire [5:0] k0_idx;
  wire [5:0] k1_idx;
  wire k0_ok;
  wire k1_ok;

  // ============================================================
  // pin synchronisers; pins are active low, idle high
  picic_sync #(.W(7), .RST(7'h7F)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin(irq_pin_n),
    .level(pin_lvl_n)
  );

  // ============================================================
  // per-source activity and keys
  genvar g;
  generate
    for (g = 0; g < 64; g = g + 1) begin : g_src
      if (g == 0) begin : g_none
        assign act0[g] = 1'b0;
        assign act1[g] = 1'b0;
        assign keys0[g*7 +: 7] = 7'h00;
        assign keys1[g*7 +: 7] = 7'h00;
      end else begin : g_live
        if (g <= 7) begin : g_pin
          localparam [31:0] PIN_N = g;
          localparam [2:0] PIN_LVL = PIN_N[2:0];
          // pin n owns the fixed slot of level n
          assign keys0[g*7 +: 7] = {PIN_LVL, `PICIC_RANK_FIXED};
          assign act0[g] = ~pin_lvl_n[g] & ~mask0_ff[g] & ~mask0_ff[0];
        end else begin : g_prog0
          assign keys0[g*7 +: 7] = key_of(lp0_ff[g]);
          // level 0 means unassigned and never requests
          assign act0[g] = src0_req[g] & ~mask0_ff[g] & ~mask0_ff[0] &
                           (lp0_ff[g][`PICIC_LP_LVL_HI:`PICIC_LP_LVL_LO] != 3'h0);
        end
        assign keys1[g*7 +: 7] = key_of(lp1_ff[g]);
        assign act1[g] = src1_req[g] & ~mask1_ff[g] & ~mask1_ff[0] &
                         (lp1_ff[g][`PICIC_LP_LVL_HI:`PICIC_LP_LVL_LO] != 3'h0);
      end
    end
  endgenerate

  // ============================================================
  // arbiters: overall best per instance, and best at the fetched level
  picic_arb u_arb0 (
    .act(act0), .keys(keys0), .lvl_en(1'b0), .lvl(3'h0),
    .best_key(b0_key), .best_idx(b0_idx), .best_ok(b0_ok)
  );
  picic_arb u_arb1 (
    .act(act1), .keys(keys1), .lvl_en(1'b0), .lvl(3'h0),
    .best_key(b1_key), .best_idx(b1_idx), .best_ok(b1_ok)
  );
  picic_arb u_ack0 (
    .act(act0), .keys(keys0), .lvl_en(1'b1), .lvl(cyc_tm),
    .best_key(k0_key), .best_idx(k0_idx), .best_ok(k0_ok)
  );
  picic_arb u_ack1 (
    .act(act1), .keys(keys1), .lvl_en(1'b1), .lvl(cyc_tm),
    .best_key(k1_key), .best_idx(k1_idx), .best_ok(k1_ok)
  );

  // instance one wins only with a strictly higher key
  wire pick1 = b1_ok & (~b0_ok | (b1_key > b0_key));
  wire [6:0] win_key = pick1 ? b1_key : b0_key;
  wire win_ok = b0_ok | b1_ok;
  wire ack_pick1 = k1_ok & (~k0_ok | (k1_key > k0_key));

  // vector fetch: byte read with the special type, modifier carries the level
  wire is_ack = cyc_valid & cyc_read & (cyc_tt == `PICIC_TT_ACK) &
                (cyc_siz == `PICIC_SIZ_BYTE) & (cyc_tm != 3'h0);

  // ============================================================
  // vector choice; nothing left at that level gives the spurious vector
  always @* begin
    nxt_ev_set = 2'h0;
    nxt_vector = `PICIC_VEC_SPUR;
    if (is_ack) begin
      if (ack_pick1) begin
        nxt_vector = `PICIC_VEC_BASE1 + {2'h0, k1_idx};
        nxt_ev_set[`PICIC_EV_SERVED] = 1'b1;
      end else if (k0_ok) begin
        nxt_vector = `PICIC_VEC_BASE0 + {2'h0, k0_idx};
        nxt_ev_set[`PICIC_EV_SERVED] = 1'b1;
      end else begin
        nxt_ev_set[`PICIC_EV_SPUR] = 1'b1;
      end
    end
  end

  // ============================================================
  // core outputs, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ipl <= 3'h0;
      ack_done <= 1'b0;
      ack_vector <= 8'h00;
      win_ff <= 14'h0000;
    end else begin
      ipl <= win_ok ? win_key[6:4] : 3'h0;
      ack_done <= is_ack;
      if (is_ack) begin
        ack_vector <= nxt_vector;
      end
      win_ff <= {win_ok, pick1, (pick1 ? b1_idx : b0_idx), win_key[6:4], 3'h0};
    end
  end

  // ============================================================
  // apb decode; one wait state so read data comes from a flop
  wire acc = psel & penable;
  wire commit = acc & pready;
  wire lp_page0 = (paddr[11:8] == `PICIC_PAGE_LP0);
  wire lp_page1 = (paddr[11:8] == `PICIC_PAGE_LP1);
  wire [5:0] lp_idx = paddr[7:2];
  wire lp_fixed = lp_page0 & (lp_idx <= 6'h07); // pin slots and index 0 are not writable

  // read mux and unmapped detection
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    if (lp_page0) begin
      nxt_rdata = lp_fixed ? 32'h00000000 : {26'h0, lp0_ff[lp_idx]};
    end else if (lp_page1) begin
      nxt_rdata = {26'h0, lp1_ff[lp_idx]};
    end else begin
      case (paddr)
        `PICIC_OFF_MASKL0: nxt_rdata = mask0_ff[31:0];
        `PICIC_OFF_MASKU0: nxt_rdata = mask0_ff[63:32];
        `PICIC_OFF_MASKL1: nxt_rdata = mask1_ff[31:0];
        `PICIC_OFF_MASKU1: nxt_rdata = mask1_ff[63:32];
        `PICIC_OFF_EVSTS: nxt_rdata = {30'h0, ev_sts_ff};
        `PICIC_OFF_EVENA: nxt_rdata = {30'h0, ev_ena_ff};
        `PICIC_OFF_WIN: nxt_rdata = {18'h0, win_ff};
        default: nxt_err = 1'b1;
      endcase
    end
  end

  // bus handshake
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & nxt_err;
      if (acc & ~pready) begin
        prdata <= pwrite ? 32'h00000000 : nxt_rdata;
      end
    end
  end

  // ============================================================
  // mask registers, all ones after reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask0_ff <= {`PICIC_MASK_RST, `PICIC_MASK_RST};
      mask1_ff <= {`PICIC_MASK_RST, `PICIC_MASK_RST};
    end else if (commit & pwrite) begin
      case (paddr)
        `PICIC_OFF_MASKL0: mask0_ff[31:0] <= pwdata;
        `PICIC_OFF_MASKU0: mask0_ff[63:32] <= pwdata;
        `PICIC_OFF_MASKL1: mask1_ff[31:0] <= pwdata;
        `PICIC_OFF_MASKU1: mask1_ff[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // level/priority entries
  integer j;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < 64; j = j + 1) begin
        lp0_ff[j] <= `PICIC_LP_RST;
        lp1_ff[j] <= `PICIC_LP_RST;
      end
    end else if (commit & pwrite) begin
      if (lp_page0 & ~lp_fixed) begin
        lp0_ff[lp_idx] <= pwdata[5:0];
      end
      if (lp_page1 & (lp_idx != 6'h00)) begin
        lp1_ff[lp_idx] <= pwdata[5:0];
      end
    end
  end

  // ============================================================
  // event status: write one to clear, a new event beats the clear
  wire [1:0] ev_clr = (commit & pwrite & (paddr == `PICIC_OFF_EVSTS)) ? pwdata[1:0] : 2'h0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_sts_ff <= `PICIC_EV_RST;
      ev_ena_ff <= `PICIC_EV_RST;
      evt_irq <= 1'b0;
    end else begin
      ev_sts_ff <= (ev_sts_ff & ~ev_clr) | nxt_ev_set;
      if (commit & pwrite & (paddr == `PICIC_OFF_EVENA)) begin
        ev_ena_ff <= pwdata[1:0];
      end
      // follows the flags one cycle late since the output is a flop
      evt_irq <= |(ev_sts_ff & ev_ena_ff);
    end
  end

endmodule

`default_nettype wire

//--- tb/picic_props.sv
// checker: port-level properties of the interrupt controller
// assumes one pclk domain; bound into picic_top at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module picic_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // sources
  input wire logic [63:8] src0_req,
  input wire logic [63:1] src1_req,
  input wire logic [7:1] irq_pin_n,
  // core side
  input wire logic cyc_valid,
  input wire logic cyc_read,
  input wire logic [1:0] cyc_tt,
  input wire logic [2:0] cyc_tm,
  input wire logic [1:0] cyc_siz,
  input wire logic [2:0] ipl,
  input wire logic ack_done,
  input wire logic [7:0] ack_vector
);
  logic fetch;
  logic wr_ok;
  logic wr_seen_ff;
  logic [2:0] quiet_ff;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====
  // helpers
  assign fetch = cyc_valid && cyc_read && cyc_tt == 2'h3 && cyc_siz == 2'h1 && cyc_tm != 3'h0;
  assign wr_ok = psel && penable && pready && pwrite;
  // pins need three edges to reach ipl, so quiet counts past that
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_seen_ff <= 1'h0;
      quiet_ff <= 3'h0;
    end else begin
      wr_seen_ff <= wr_seen_ff | wr_ok;
      if (wr_ok || $changed(src0_req) || $changed(src1_req) || $changed(irq_pin_n)) begin
        quiet_ff <= 3'h0;
      end else if (quiet_ff != 3'h7) begin
        quiet_ff <= quiet_ff + 3'h1;
      end
    end
  end
  // =====
  // properties
  property p_ack; fetch |=> ack_done; endproperty
  a_ack: assert property (p_ack) else $error("fetch not answered");
  property p_ack_src; ack_done |-> $past(fetch); endproperty
  a_ack_src: assert property (p_ack_src) else $error("answer without fetch");
  property p_vec; ack_done |-> ack_vector inside {[8'h40:8'hBF], 8'h18}; endproperty
  a_vec: assert property (p_vec) else $error("vector out of range");
  property p_vec_hold; !ack_done |-> $stable(ack_vector); endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  property p_rst_quiet; !wr_seen_ff |-> ipl == 3'h0; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("level before setup");
  property p_ipl_hold; quiet_ff >= 3'h4 |-> $stable(ipl); endproperty
  a_ipl_hold: assert property (p_ipl_hold) else $error("level moved uncaused");
  property p_ws; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  a_ws: assert property (p_ws) else $error("wait state wrong");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  c_spur: cover property (ack_done && ack_vector == 8'h18);
  c_top: cover property (ipl == 3'h7);
  c_err: cover property (pslverr);
endmodule
bind picic_top picic_props i_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .src0_req(src0_req),
  .src1_req(src1_req), .irq_pin_n(irq_pin_n), .cyc_valid(cyc_valid),
  .cyc_read(cyc_read), .cyc_tt(cyc_tt), .cyc_tm(cyc_tm), .cyc_siz(cyc_siz),
  .ipl(ipl), .ack_done(ack_done), .ack_vector(ack_vector)
);
`default_nettype wire

//--- tb/picic_core.sv
// partner: behavioural core taking interrupts from the controller
// assumes it shares pclk; en, sr_clr and spur come from the bench
`timescale 1ns/1ps
`default_nettype none
module picic_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control
  input wire logic en,
  input wire logic sr_clr,
  input wire logic spur,
  // controller side
  input wire logic [2:0] ipl,
  input wire logic ack_done,
  input wire logic [7:0] ack_vector,
  output logic cyc_valid,
  output logic cyc_read,
  output logic [1:0] cyc_tt,
  output logic [2:0] cyc_tm,
  output logic [1:0] cyc_siz,
  // results
  output logic [7:0] vec,
  output logic [7:0] n_taken
);
  logic busy, sup_mode;
  logic [2:0] sr_i, ipl_d, lvl;
  logic take;
  // above the mask, or a fresh level 7 whatever the mask
  assign take = en && (ipl > sr_i || (ipl == 3'h7 && ipl_d != 3'h7));
  // one exception at a time; idle attribute lines toggle so stale values never match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cyc_valid, cyc_read, cyc_tt, cyc_siz, cyc_tm, busy, sup_mode} <= 11'h0;
      {sr_i, ipl_d, lvl} <= 9'h1C0;
      {vec, n_taken} <= 16'h0;
    end else begin
      ipl_d <= ipl;
      cyc_valid <= 1'h0;
      {cyc_read, cyc_tt, cyc_siz, cyc_tm} <= ~{cyc_read, cyc_tt, cyc_siz, cyc_tm};
      if (sr_clr) begin
        {sr_i, sup_mode} <= 4'h0;
      end
      if (busy && ack_done) begin
        busy <= 1'h0;
        vec <= ack_vector; // index of a 256-entry table
        sr_i <= lvl;
        n_taken <= n_taken + 8'h1;
      end else if (!busy && (take || spur)) begin
        {busy, sup_mode, cyc_valid, cyc_read} <= 4'hF;
        {cyc_tt, cyc_siz} <= 4'hD;
        cyc_tm <= spur ? 3'h1 : ipl;
        lvl <= spur ? 3'h1 : ipl;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/picic_top_tb.sv
// testbench: apb, source and core-side scenarios for the interrupt controller
// assumes picic_top, picic_core and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module picic_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic cyc_valid, cyc_read, ack_done, evt_irq, en, sr_clr, spur;
  logic [1:0] cyc_tt, cyc_siz;
  logic [2:0] cyc_tm, ipl;
  logic [7:0] ack_vector, vec, n_taken;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:8] src0_req;
  logic [63:1] src1_req;
  logic [7:1] irq_pin_n;
  int n_errors, samples_checked, cycles;
  // =====
  // design and core model
  picic_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src0_req(src0_req), .src1_req(src1_req), .irq_pin_n(irq_pin_n),
    .cyc_valid(cyc_valid), .cyc_read(cyc_read), .cyc_tt(cyc_tt), .cyc_tm(cyc_tm),
    .cyc_siz(cyc_siz), .ipl(ipl), .ack_done(ack_done), .ack_vector(ack_vector),
    .evt_irq(evt_irq)
  );
  picic_core i_core (
    .pclk(pclk), .presetn(presetn), .en(en), .sr_clr(sr_clr), .spur(spur), .ipl(ipl),
    .ack_done(ack_done), .ack_vector(ack_vector), .cyc_valid(cyc_valid),
    .cyc_read(cyc_read), .cyc_tt(cyc_tt), .cyc_tm(cyc_tm), .cyc_siz(cyc_siz),
    .vec(vec), .n_taken(n_taken)
  );
  // clock, 4 ns period
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // =====
  // shared tasks
  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      n_errors++;
    end
  endtask
  // whole run is a few hundred cycles; a hang ends here
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      $display("[FAIL] run length expected below 5000 seen 5000");
      n_errors++;
      give_verdict();
    end
  end
  // apb transfer: request held until pready is seen at an edge
  // no own limit: only the run timeout ends a wait for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
  endtask
  task automatic rdx(input logic [11:0] a, input logic [31:0] ex);
    apb(1'h0, a, 32'h0);
    chk("prdata", ex, rd);
  endtask
  // drop the core's mask (or force a stray fetch) and check the vector taken
  task automatic take(input logic s, input logic [7:0] ev);
    logic [7:0] n0;
    n0 = n_taken;
    @(posedge pclk);
    {sr_clr, spur} <= {!s, s};
    @(posedge pclk);
    {sr_clr, spur} <= 2'h0;
    while (n_taken === n0) begin
      @(posedge pclk);
    end
    chk("vector", 32'(ev), 32'(vec));
  endtask
  // =====
  // scenarios
  task automatic t_reset;
    for (int i = 0; i < 4; i++) rdx(12'(4 * i), 32'hFFFFFFFF);
    apb(1'h0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, 32'(err));
  endtask
  task automatic t_mask;
    src1_req[5] <= 1'h1;
    apb(1'h1, 12'h214, 32'h1A);
    chk("ipl", 32'h0, 32'(ipl));
    apb(1'h1, 12'h008, 32'hFFFFFFDE);
    repeat (2) @(posedge pclk);
    chk("ipl", 32'h3, 32'(ipl));
    apb(1'h1, 12'h008, 32'hFFFFFFDF);
    repeat (2) @(posedge pclk);
    chk("ipl", 32'h0, 32'(ipl));
    apb(1'h1, 12'h008, 32'hFFFFFFFE);
    repeat (2) @(posedge pclk);
    chk("ipl", 32'h0, 32'(ipl));
    apb(1'h1, 12'h008, 32'hFFFFFFDE);
    take(1'h0, 8'h85);
  endtask
  task automatic t_rank;
    apb(1'h1, 12'h128, 32'h23);
    apb(1'h1, 12'h12C, 32'h24);
    apb(1'h1, 12'h000, 32'hFFFFF3EE);
    src0_req[11:10] <= 2'h3;
    irq_pin_n[4] <= 1'h0;
    take(1'h0, 8'h4B);
    apb(1'h1, 12'h000, 32'hFFFFFBEE);
    take(1'h0, 8'h44);
    irq_pin_n[4] <= 1'h1;
    take(1'h0, 8'h4A);
  endtask
  task automatic t_tie;
    apb(1'h1, 12'h150, 32'h35);
    apb(1'h1, 12'h250, 32'h35);
    apb(1'h1, 12'h000, 32'hFFEFFBEE);
    apb(1'h1, 12'h008, 32'hFFEFFFDE);
    src0_req[20] <= 1'h1;
    src1_req[20] <= 1'h1;
    take(1'h0, 8'h54);
    apb(1'h1, 12'h254, 32'h36);
    apb(1'h1, 12'h008, 32'hFFCFFFDE);
    src1_req[21] <= 1'h1;
    take(1'h0, 8'h95);
    irq_pin_n[7] <= 1'h0;
    apb(1'h1, 12'h000, 32'hFFEFFB6E);
    take(1'h0, 8'h47);
    chk("ipl", 32'h7, 32'(ipl));
  endtask
  task automatic t_event;
    en <= 1'h0;
    irq_pin_n[7] <= 1'h1;
    take(1'h1, 8'h18);
    chk("evt_irq", 32'h0, 32'(evt_irq));
    apb(1'h1, 12'h014, 32'h3);
    repeat (2) @(posedge pclk);
    chk("evt_irq", 32'h1, 32'(evt_irq));
    rdx(12'h010, 32'h3);
    apb(1'h1, 12'h010, 32'h3);
    repeat (2) @(posedge pclk);
    chk("evt_irq", 32'h0, 32'(evt_irq));
    rdx(12'h010, 32'h0);
    // winner word: valid, instance one, source 21, level 6
    rdx(12'h018, 32'h3570);
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sr_clr, spur} = '0;
    {src0_req, src1_req, irq_pin_n} = {119'h0, 7'h7F};
    {presetn, en, n_errors, samples_checked, cycles} = {2'h1, 96'h0};
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_mask();
    t_rank();
    t_tie();
    t_event();
    give_verdict();
  end
endmodule
`default_nettype wire
